// File: lsc_pkg.sv
// Shared constants and types of the light sensor control register block
package lsc_pkg;
   // Register pointer values
   localparam logic [3:0] ADDR_MODE   = 4'h0;
   localparam logic [3:0] ADDR_SETUP  = 4'h1;
   localparam logic [3:0] ADDR_RES_LO = 4'h4;
   localparam logic [3:0] ADDR_RES_HI = 4'h5;
   localparam logic [3:0] ADDR_ID     = 4'ha;
   localparam logic [3:0] ADDR_LAST   = 4'hd;
   localparam logic [3:0] ADDR_FIRST  = 4'h0;

   // Field positions and reset values
   localparam int         CMD_SEL_BIT = 7;
   localparam int         SKIP_BIT    = 3;
   localparam logic [7:0] MODE_RESET  = 8'h00;
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [3:0] ID_LOW_NIB  = 4'h0;

   // Operating mode codes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_RSV = 2'h1;
   localparam logic [1:0] MODE_ONE = 2'h2;
   localparam logic [1:0] MODE_RUN = 2'h3;

   // Timing: integration at multiplier 1 and power-save gap at multiplier 1
   localparam int CLK_HZ      = 10_000_000;
   localparam int INT_MAX_MS  = 400;
   localparam int SAVE_MS     = 60;
   localparam int INT_MAX_CYC = INT_MAX_MS * (CLK_HZ / 1000);
   localparam int SAVE_CYC    = SAVE_MS * (CLK_HZ / 1000);

   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_INT  = 3'b010,
      ST_SAVE = 3'b100
   } lsc_state_e;

   // Byte-level requests from the serial interface front end
   typedef struct packed {
      logic       cmd;   // Command byte strobe
      logic       wr;    // Data write strobe
      logic       rd;    // Data read strobe
      logic [7:0] data;  // Command or write byte
   } lsc_req_s;
endpackage : lsc_pkg

// File: lsc_light_regs.sv
// Control, timing and result registers of the ambient light sensor
`timescale 1ns/1ps
module lsc_light_regs #(
   parameter int         INT_CYC   = lsc_pkg::INT_MAX_CYC, // 400 ms in cycles
   parameter int         GAP_CYC   = lsc_pkg::SAVE_CYC,    // 60 ms in cycles
   parameter int         CNT_W     = 23,                   // Cycle counter width
   parameter logic [3:0] PART_CODE = 4'h3                  // Arbitrary part code
) (
   input  wire logic             sys_clk,     // 10 MHz clock
   input  wire logic             sys_rst,     // Asynchronous reset, active high
   input  wire logic             clkEn,       // Freezes all state while low
   input  wire lsc_pkg::lsc_req_s busReq,     // Byte requests from serial front end
   input  wire logic [15:0]      adcValue,    // Conversion value in lux
   output logic [7:0]            rdData,      // Read byte
   output logic                  rdValid,     // Read byte valid, one cycle
   output logic                  integrating, // Light integration in progress
   output logic                  lowPower     // Front end powered down or in gap
);
   // Elaboration-time refusal of counts that the counter cannot hold
   if (CNT_W < 3 || INT_CYC < 4 || GAP_CYC < 4 || INT_CYC >= (1 << CNT_W)
       || GAP_CYC >= (1 << CNT_W)) begin : g_bad_counts
      $error("lsc_light_regs: counts do not fit the counter");
   end

   localparam logic [CNT_W-1:0] INT_LEN = CNT_W'(INT_CYC);
   localparam logic [CNT_W-1:0] GAP_LEN = CNT_W'(GAP_CYC);

   lsc_pkg::lsc_state_e state, next_state;
   logic [CNT_W-1:0]    cnt, next_cnt;
   logic [7:0]          modeReg, next_modeReg;
   logic [7:0]          setupReg, next_setupReg;
   logic [15:0]         result, next_result;
   logic [7:0]          hiHold, next_hiHold;
   logic [3:0]          ptr, next_ptr;
   logic [7:0]          next_rdData;
   logic                next_rdValid;
   logic                xferNow;
   logic                modeWr;
   logic [CNT_W-1:0]    intLen, gapLen;

   // Multiplier 1, 2 or 4 divides the base length; reserved code acts as 1
   function automatic logic [CNT_W-1:0] scaled(input logic [CNT_W-1:0] base,
                                               input logic [1:0] sel);
      case (sel)
         2'h1:    scaled = base >> 1;
         2'h2:    scaled = base >> 2;
         default: scaled = base;
      endcase
   endfunction : scaled

   always_comb begin
      intLen = scaled(INT_LEN, setupReg[1:0]);
      gapLen = scaled(GAP_LEN, setupReg[1:0]);
      // A command byte outranks a write strobe in the same cycle
      modeWr = busReq.wr && !busReq.cmd && (ptr == lsc_pkg::ADDR_MODE);
   end

   // Conversion sequencer
   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_modeReg = modeReg;
      next_result  = result;
      xferNow      = 1'b0;
      case (state)
         lsc_pkg::ST_OFF: begin
            if (modeReg[1]) begin
               next_state = lsc_pkg::ST_INT;
               next_cnt   = intLen - 1'b1;
            end
         end
         lsc_pkg::ST_INT: begin
            if (!modeReg[1]) begin
               next_state = lsc_pkg::ST_OFF;
            end else if (cnt == '0) begin
               xferNow     = 1'b1;
               next_result = adcValue;
               if (modeReg[1:0] == lsc_pkg::MODE_ONE) begin
                  next_state   = lsc_pkg::ST_OFF;
                  next_modeReg = {modeReg[7:2], lsc_pkg::MODE_OFF};
               end else if (setupReg[lsc_pkg::SKIP_BIT]) begin
                  next_cnt = intLen - 1'b1;
               end else begin
                  next_state = lsc_pkg::ST_SAVE;
                  next_cnt   = gapLen - 1'b1;
               end
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         lsc_pkg::ST_SAVE: begin
            if (modeReg[1:0] != lsc_pkg::MODE_RUN) begin
               next_state = lsc_pkg::ST_OFF;
            end else if (cnt == '0) begin
               next_state = lsc_pkg::ST_INT;
               next_cnt   = intLen - 1'b1;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         default: begin
            next_state = lsc_pkg::ST_OFF;
         end
      endcase
      // A host write to the mode register wins over the self-clear
      if (modeWr) begin
         next_modeReg = busReq.data;
      end
   end

   // Register access: command byte with bit 7 set sets pointer, reads auto-increment
   always_comb begin
      next_setupReg = setupReg;
      next_ptr      = ptr;
      next_hiHold   = hiHold;
      next_rdData   = rdData;
      next_rdValid  = 1'b0;
      if (busReq.cmd) begin
         if (busReq.data[lsc_pkg::CMD_SEL_BIT]) begin
            next_ptr = busReq.data[3:0];
         end
      end else if (busReq.wr) begin
         if (ptr == lsc_pkg::ADDR_SETUP) begin
            next_setupReg = busReq.data;
         end
      end else if (busReq.rd) begin
         next_rdValid = 1'b1;
         if (ptr == lsc_pkg::ADDR_MODE) begin
            next_rdData = modeReg;
         end else if (ptr == lsc_pkg::ADDR_SETUP) begin
            next_rdData = setupReg;
         end else if (ptr == lsc_pkg::ADDR_RES_LO) begin
            next_rdData = result[7:0];
            next_hiHold = result[15:8];
         end else if (ptr == lsc_pkg::ADDR_RES_HI) begin
            next_rdData = hiHold;
         end else if (ptr == lsc_pkg::ADDR_ID) begin
            next_rdData = {PART_CODE, lsc_pkg::ID_LOW_NIB};
         end else begin
            next_rdData = 8'h00;
         end
         if (ptr >= lsc_pkg::ADDR_LAST) begin
            next_ptr = lsc_pkg::ADDR_FIRST;
         end else begin
            next_ptr = ptr + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state    <= lsc_pkg::ST_OFF;
         cnt      <= '0;
         modeReg  <= lsc_pkg::MODE_RESET;
         setupReg <= lsc_pkg::SETUP_RESET;
         result   <= 16'h0000;
         hiHold   <= 8'h00;
         ptr      <= lsc_pkg::ADDR_FIRST;
         rdData   <= 8'h00;
         rdValid  <= 1'b0;
      end else if (clkEn) begin
         state    <= next_state;
         cnt      <= next_cnt;
         modeReg  <= next_modeReg;
         setupReg <= next_setupReg;
         result   <= next_result;
         hiHold   <= next_hiHold;
         ptr      <= next_ptr;
         rdData   <= next_rdData;
         rdValid  <= next_rdValid;
      end
   end

   assign integrating = (state == lsc_pkg::ST_INT);
   assign lowPower    = (state != lsc_pkg::ST_INT);

   // Checks
   sequence sXfer;
      clkEn && xferNow && !modeWr;
   endsequence

   sequence sGapEnd;
      clkEn && state == lsc_pkg::ST_SAVE && cnt == '0
         && modeReg[1:0] == lsc_pkg::MODE_RUN && !modeWr;
   endsequence

   sequence sLowRead;
      clkEn && busReq.rd && !busReq.cmd && !busReq.wr && ptr == lsc_pkg::ADDR_RES_LO;
   endsequence

   a_single_shot_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sXfer and (modeReg[1:0] == lsc_pkg::MODE_ONE)
         |=> state == lsc_pkg::ST_OFF && modeReg[1:0] == lsc_pkg::MODE_OFF)
      else $error("single conversion did not return to power down");

   a_off_mode_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && !modeReg[1] |=> state == lsc_pkg::ST_OFF)
      else $error("power down mode left the sequencer running");

   a_skip_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sXfer and (modeReg[1:0] == lsc_pkg::MODE_RUN) and setupReg[lsc_pkg::SKIP_BIT]
         |=> state == lsc_pkg::ST_INT && cnt == $past(intLen) - 1'b1)
      else $error("skip did not restart integration at once");

   a_gap_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sXfer and (modeReg[1:0] == lsc_pkg::MODE_RUN) and !setupReg[lsc_pkg::SKIP_BIT]
         |=> state == lsc_pkg::ST_SAVE && cnt == $past(gapLen) - 1'b1)
      else $error("power save gap length wrong");

   a_run_repeats: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sGapEnd |=> state == lsc_pkg::ST_INT && cnt == $past(intLen) - 1'b1)
      else $error("continuous mode did not start a new integration");

   a_int_scale: assert property (@(posedge sys_clk) disable iff (sys_rst)
      setupReg[1:0] == 2'h2 |-> intLen == CNT_W'(INT_CYC / 4))
      else $error("integration length does not match selection");

   a_result_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && xferNow |=> result == $past(adcValue))
      else $error("conversion not transferred whole");

   a_high_held: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sLowRead |=> hiHold == $past(result[15:8]) && rdData == $past(result[7:0]) && rdValid)
      else $error("low byte read did not hold the high byte");

   a_id_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && busReq.rd && !busReq.cmd && !busReq.wr && ptr == lsc_pkg::ADDR_ID
         |=> rdValid && rdData[7:4] == PART_CODE)
      else $error("identity read returned wrong part code");

   a_ptr_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clkEn && busReq.rd && !busReq.cmd && !busReq.wr && ptr == lsc_pkg::ADDR_LAST
         |=> ptr == lsc_pkg::ADDR_FIRST)
      else $error("read pointer did not wrap to zero");
endmodule : lsc_light_regs

// File: lsc_host_model.sv
// Host model that issues register byte requests
`timescale 1ns/1ps
module lsc_host_model (
   input  wire logic        sys_clk, // Bus clock
   input  wire logic [7:0]  rdData,  // Read byte
   input  wire logic        rdValid, // Read byte valid
   output lsc_pkg::lsc_req_s busReq  // Byte requests
);
   initial busReq = '0;

   // One strobe for one cycle; released data is inverted so no stale byte lingers
   task step(input logic c, input logic w, input logic r, input logic [7:0] d);
      @(negedge sys_clk);
      busReq = {c, w, r, d};
      @(negedge sys_clk);
      busReq = {3'h0, ~d};
   endtask : step

   task point(input logic [3:0] a);
      step(1'b1, 1'b0, 1'b0, {4'h8, a});
   endtask : point

   task writeReg(input logic [3:0] a, input logic [7:0] d);
      point(a);
      step(1'b0, 1'b1, 1'b0, d & (a == 4'h0 ? 8'h03 : 8'h0b));
   endtask : writeReg

   task readNext(output logic [7:0] d, output logic v);
      step(1'b0, 1'b0, 1'b1, 8'h00);
      d = rdData;
      v = rdValid;
   endtask : readNext
endmodule : lsc_host_model

// File: lsc_light_regs_test.sv
// Self-checking bench of the light sensor register block
`timescale 1ns/1ps
module lsc_light_regs_test;
   localparam int         INT   = 16;
   localparam int         GAP   = 8;
   localparam logic [3:0] PCODE = 4'h6; // Arbitrary part code
   logic              sys_clk      = 1'b0;
   logic              sys_rst      = 1'b1;
   logic              clkEn        = 1'b1;
   logic [15:0]       adcValue     = 16'h639c;
   lsc_pkg::lsc_req_s busReq;
   logic [7:0]        rdData;
   logic              rdValid;
   logic              integrating;
   logic              lowPower;
   int                failures     = 0;
   int                total_checks = 0;
   int                cycles       = 0;

   always #50 sys_clk = ~sys_clk;

   lsc_light_regs #(.INT_CYC(INT), .GAP_CYC(GAP), .PART_CODE(PCODE)) i_dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .busReq(busReq),
      .adcValue(adcValue), .rdData(rdData), .rdValid(rdValid),
      .integrating(integrating), .lowPower(lowPower));
   lsc_host_model i_host (.sys_clk(sys_clk), .rdData(rdData), .rdValid(rdValid),
      .busReq(busReq));

   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task rdNext(input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      i_host.readNext(d, v);
      chk(16'(v), 16'h0001);
      chk(16'(d), 16'(exp));
   endtask : rdNext

   task rdAt(input logic [3:0] a, input logic [7:0] exp);
      i_host.point(a);
      rdNext(exp);
   endtask : rdAt

   // Counts falling edges while integrating stays at lv
   task countLevel(input logic lv, input int lim, output int n);
      n = 0;
      while (integrating === lv && n < lim) begin
         n++;
         @(negedge sys_clk);
      end
   endtask : countLevel

   task t_reset;
      chk(16'(lowPower), 16'h0001);
      rdAt(4'h0, 8'h00);
      rdNext(8'h00);
   endtask : t_reset

   task t_id;
      logic [7:0] d;
      logic       v;
      i_host.writeReg(4'h1, 8'h0b);
      i_host.point(4'ha);
      i_host.readNext(d, v);
      chk(16'(d & 8'hf0), {8'h00, PCODE, 4'h0});
      for (int i = 0; i < 4; i++) rdNext(8'h00);
      rdNext(8'h0b);
   endtask : t_id

   task t_single;
      int n;
      i_host.writeReg(4'h1, 8'h00);
      i_host.writeReg(4'h0, 8'h02);
      countLevel(1'b0, 200, n);
      clkEn = 1'b0;
      repeat (5) @(negedge sys_clk);
      chk(16'(integrating), 16'h0001);
      clkEn = 1'b1;
      countLevel(1'b1, 200, n);
      chk(16'(n), 16'(INT));
      rdAt(4'h0, 8'h00);
      rdAt(4'h4, 8'h9c);
      adcValue = 16'ha55a;
      i_host.writeReg(4'h0, 8'h02);
      countLevel(1'b0, 200, n);
      countLevel(1'b1, 200, n);
      rdAt(4'h5, 8'h63);
      rdAt(4'h4, 8'h5a);
      rdNext(8'ha5);
   endtask : t_single

   task t_run;
      int n;
      int g;
      int sh;
      for (int s = 0; s < 8; s++) begin
         // Reserved timer code 11 behaves as the 400 ms selection
         sh = (s[2:1] == 2'h3) ? 0 : int'(s[2:1]);
         i_host.writeReg(4'h1, {4'h0, s[0], 1'b0, s[2:1]});
         i_host.writeReg(4'h0, 8'h03);
         countLevel(1'b0, 200, n);
         countLevel(1'b1, 64, n);
         chk(16'(lowPower), 16'(!s[0]));
         countLevel(1'b0, 64, g);
         if (s[0]) chk(16'(n), 16'd64);
         else begin
            chk(16'(n), 16'(INT >> sh));
            chk(16'(g), 16'(GAP >> sh));
         end
         i_host.writeReg(4'h0, 8'h00);
         @(negedge sys_clk);
         chk(16'(integrating), 16'h0000);
      end
   endtask : t_run

   task t_refuse;
      i_host.writeReg(4'h1, 8'h02);
      i_host.step(1'b1, 1'b0, 1'b0, 8'h04);
      rdNext(8'h02);
      i_host.writeReg(4'h4, 8'hff);
      rdAt(4'h4, 8'h5a);
      i_host.writeReg(4'h0, 8'h01);
      repeat (20) @(negedge sys_clk);
      chk(16'(integrating), 16'h0000);
   endtask : t_refuse

   task end_of_test;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures++;
         end_of_test();
      end
   end

   initial begin
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_reset();
      t_id();
      t_single();
      t_run();
      t_refuse();
      end_of_test();
   end
endmodule : lsc_light_regs_test
